// >>> hdl/erx_spi_cmd.v
// Notes on behaviour
// RULE1 - 101 writes config, next frame detailed faults
// RULE2 - 010 keeps config, next frame fault/levels
// RULE3 - 111 keeps config, next frame shows config
// RULE4 - other codes keep config, detailed faults next
// RULE5 - status snapshot taken at chip select fall
// RULE6 - high-threshold bit enables se thresholds in htl
// RULE7 - detailed word 16 bits with differential flags
// RULE8 - detailed word holds per-input single-ended flags
// RULE9 - receiver fault bit is diff or se fault
// RULE10 - fault raises interrupt and receiver fault output
// RULE11 - single-ended faults always take the long filter
// RULE12 - filter bit set: diff faults take long filter
// RULE13 - filter bit clear: diff faults take 10us
// RULE14 - fault output follows fault, interrupt stays latched
// RULE15 - status read releases interrupt despite lasting fault
// RULE16 - a/b pair: 00 dhtl 01 rs422 10 sehtl 11 ttl
// RULE17 - z digital bit forces di, else table
// RULE18 - y: x0 rs422, 01 di, 11 ttl
// RULE19 - aux select bit: 0 ttl, 1 di
// RULE20 - under 16 clocks dropped, over 16 keeps last
// RULE21 - sample input on rise, launch output on fall
// RULE22 - after reset config zero, first frame zeros
// RULE23 - frame is 3 command bits plus 13 mode bits
// RULE24 - msb first, command in top three bits
`timescale 1ns/1ps
`default_nettype none
`include "erx_defines.vh"
module erx_spi_cmd #(
   parameter [`ERX_FILTER_CNT_W-1:0] LONG_FILTER_CYC = `ERX_LONG_FILTER_CYC
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire chip_select_pin_n_i,
   input wire serial_clock_pin_i,
   input wire serial_in_pin_i,
   input wire [3:0] diff_fault_i,
   input wire [11:0] se_fault_i,
   input wire [5:0] rx_level_i,
   output reg serial_out_pin_o,
   output reg shared_interrupt_n_o,
   output reg [5:0] fault_o,
   output reg [2:0] a_mode_o,
   output reg [2:0] b_mode_o,
   output reg [2:0] z_mode_o,
   output reg [2:0] y_mode_o,
   output reg [2:0] aux2_mode_o,
   output reg [2:0] aux3_mode_o,
   output reg [2:0] se_htl_thresh_o,
   output reg diff_filter_en_o
);
   // synchronised pins and sense inputs
   wire [2:0] spi_s;
   wire [21:0] sense_s;
   wire cs_n_s;
   wire sclk_s;
   wire sdi_s;
   wire [3:0] diff_s;
   wire [11:0] se_s;
   wire [5:0] level_s;

   // chip select resets to its idle high level, so no false edge follows
   erx_sync #(.W(3), .RST_VAL(3'h4)) u_spi_sync (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i({chip_select_pin_n_i, serial_clock_pin_i, serial_in_pin_i}),
      .sync_o(spi_s)
   );

   erx_sync #(.W(22)) u_sense_sync (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .async_i({diff_fault_i, se_fault_i, rx_level_i}),
      .sync_o(sense_s)
   );

   assign cs_n_s = spi_s[2];
   assign sclk_s = spi_s[1];
   assign sdi_s = spi_s[0];
   assign diff_s = sense_s[21:18];
   assign se_s = sense_s[17:6];
   assign level_s = sense_s[5:0];

   // detailed fault word, bit 15 down to 0
   wire [15:0] detail_word;
   assign detail_word = {se_s[11:10], diff_s[3],
                         se_s[9:8], diff_s[2],
                         se_s[7:6], diff_s[1],
                         se_s[5:4], diff_s[0],
                         se_s[3:0]}; // RULE7 RULE8

   // single-ended fault per receiver a b z y aux2 aux3
   wire [5:0] se_any;
   assign se_any = {|se_s[11:10], |se_s[9:8], |se_s[7:6],
                    |se_s[5:4], |se_s[3:2], |se_s[1:0]};

   // held configuration
   reg [`ERX_MODE_W-1:0] cfg;
   wire diff_filter_en;
   assign diff_filter_en = cfg[`ERX_BIT_DIFF_FILTER_EN];

   // fault qualification filters
   wire [5:0] se_qual;
   wire [3:0] diff_qual;
   genvar gi;
   generate
      // single-ended faults always take the long delay
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_se
         erx_fault_filter #(
            .LONG_CYC(LONG_FILTER_CYC),
            .SHORT_CYC(LONG_FILTER_CYC)
         ) u_se_filt (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .raw_i(se_any[gi]),
            .short_i(1'b0),
            .qual_o(se_qual[gi])
         ); // RULE11
      end
      // differential delay shortens while the filter bit is clear
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_diff
         erx_fault_filter #(
            .LONG_CYC(LONG_FILTER_CYC),
            .SHORT_CYC(`ERX_SHORT_FILTER_CYC)
         ) u_diff_filt (
            .clk_sys_i(clk_sys_i),
            .nrst_i(nrst_i),
            .raw_i(diff_s[gi]),
            .short_i(~diff_filter_en),
            .qual_o(diff_qual[gi])
         ); // RULE12 RULE13
      end
   endgenerate

   // qualified fault per receiver, diff or single-ended
   wire [5:0] qual;
   assign qual = se_qual | {diff_qual, 2'b00}; // RULE9

   // edge detection on synchronised pins
   reg cs_n_d;
   reg sclk_d;
   wire cs_fall;
   wire cs_rise;
   wire sclk_rise;
   wire sclk_fall;

   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs_n_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         cs_n_d <= cs_n_s;
         sclk_d <= sclk_s;
      end
   end

   assign cs_fall = cs_n_d & ~cs_n_s;
   assign cs_rise = ~cs_n_d & cs_n_s;
   // serial clock edges only count while chip select is low
   assign sclk_rise = ~cs_n_s & ~sclk_d & sclk_s;
   assign sclk_fall = ~cs_n_s & sclk_d & ~sclk_s;

   // frame state
   reg [15:0] rx_shift;
   reg [15:0] tx_shift;
   reg [4:0] bit_cnt;
   reg [1:0] resp_sel;
   reg [1:0] frame_resp;
   wire frame_ok;
   wire [2:0] cmd;
   wire read_done;

   assign frame_ok = cs_rise && (bit_cnt == `ERX_FRAME_BITS); // RULE20
   assign cmd = rx_shift[`ERX_CMD_HI:`ERX_CMD_LO]; // RULE23 RULE24
   assign read_done = frame_ok && ((frame_resp == `ERX_RESP_DETAIL) ||
                                   (frame_resp == `ERX_RESP_STATUS));

   // status and configuration readback words
   wire [15:0] status_word;
   wire [15:0] config_word;
   assign status_word = {qual, level_s, 4'h0}; // RULE2 RULE9
   assign config_word = {3'h0, cfg}; // RULE3

   // response word chosen at the start of a frame
   reg [15:0] resp_word;
   always @* begin
      case (resp_sel)
         `ERX_RESP_DETAIL: resp_word = detail_word;
         `ERX_RESP_STATUS: resp_word = status_word;
         `ERX_RESP_CONFIG: resp_word = config_word; // RULE3
         default: resp_word = 16'h0000; // RULE22
      endcase
   end

   // receive shift, bit count, transmit shift
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_shift <= 16'h0000;
         tx_shift <= 16'h0000;
         bit_cnt <= 5'h00;
         frame_resp <= `ERX_RESP_ZERO;
         serial_out_pin_o <= 1'b0;
      end else if (cs_fall) begin
         // a new frame starts with the response chosen by the last one
         bit_cnt <= 5'h00;
         tx_shift <= resp_word; // RULE5
         frame_resp <= resp_sel;
         serial_out_pin_o <= resp_word[15];
      end else begin
         // input bits enter on each rising serial clock
         if (sclk_rise) begin
            rx_shift <= {rx_shift[14:0], sdi_s}; // RULE21
            if (bit_cnt != `ERX_FRAME_BITS) begin
               bit_cnt <= bit_cnt + 5'h01;
            end
         end
         if (sclk_fall) begin
            // extra clocks pass input data through after 16 bits
            tx_shift <= {tx_shift[14:0], rx_shift[0]};
            serial_out_pin_o <= tx_shift[14]; // RULE21
         end
      end
   end

   // command decode at the end of a complete frame
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg <= `ERX_CFG_RESET; // RULE22
         resp_sel <= `ERX_RESP_ZERO;
      end else if (frame_ok) begin
         // frames under 16 clocks never reach this decode
         case (cmd)
            `ERX_CMD_CONFIG_WRITE: begin
               cfg <= rx_shift[`ERX_MODE_W-1:0]; // RULE1
               resp_sel <= `ERX_RESP_DETAIL;
            end
            `ERX_CMD_STATUS_READ: begin
               resp_sel <= `ERX_RESP_STATUS; // RULE2
            end
            `ERX_CMD_CONFIG_READ: begin
               resp_sel <= `ERX_RESP_CONFIG; // RULE3
            end
            default: begin
               resp_sel <= `ERX_RESP_DETAIL; // RULE4
            end
         endcase
      end
   end

   // new qualified fault events
   reg [5:0] qual_d;
   wire new_fault;
   assign new_fault = |(qual & ~qual_d);

   // fault outputs follow, interrupt latches until a status or detailed fault read
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         qual_d <= 6'h00;
         fault_o <= 6'h00;
         shared_interrupt_n_o <= 1'b1;
      end else begin
         qual_d <= qual;
         fault_o <= qual; // RULE10 RULE14
         // a new fault wins over a release in the same cycle
         if (new_fault) begin
            shared_interrupt_n_o <= 1'b0; // RULE10
         end else if (read_done) begin
            shared_interrupt_n_o <= 1'b1; // RULE14 RULE15
         end
      end
   end

   // receiver mode decode from the held configuration
   reg [2:0] next_a_mode;
   reg [2:0] next_b_mode;
   reg [2:0] next_z_mode;
   reg [2:0] next_y_mode;
   always @* begin
      // a and b: single-ended bit, then ttl bit
      case ({cfg[`ERX_BIT_A_SINGLE_ENDED_SEL], cfg[`ERX_BIT_A_TTL]})
         2'b00: next_a_mode = `ERX_MODE_DHTL;
         2'b01: next_a_mode = `ERX_MODE_RS422;
         2'b10: next_a_mode = `ERX_MODE_SEHTL;
         default: next_a_mode = `ERX_MODE_TTL;
      endcase // RULE16
      case ({cfg[`ERX_BIT_B_SINGLE_ENDED_SEL], cfg[`ERX_BIT_B_TTL]})
         2'b00: next_b_mode = `ERX_MODE_DHTL;
         2'b01: next_b_mode = `ERX_MODE_RS422;
         2'b10: next_b_mode = `ERX_MODE_SEHTL;
         default: next_b_mode = `ERX_MODE_TTL;
      endcase // RULE16
      // z: digital-input bit overrides its table
      if (cfg[`ERX_BIT_Z_DI]) begin
         next_z_mode = `ERX_MODE_DI; // RULE17
      end else begin
         case ({cfg[`ERX_BIT_Z_TTL], cfg[`ERX_BIT_Z_SINGLE_ENDED_SEL]})
            2'b00: next_z_mode = `ERX_MODE_DHTL;
            2'b01: next_z_mode = `ERX_MODE_SEHTL;
            2'b10: next_z_mode = `ERX_MODE_RS422;
            default: next_z_mode = `ERX_MODE_TTL;
         endcase // RULE17
      end
      // y: ttl bit, then single-ended bit
      case ({cfg[`ERX_BIT_Y_TTL], cfg[`ERX_BIT_Y_SINGLE_ENDED_SEL]})
         2'b01: next_y_mode = `ERX_MODE_DI;
         2'b11: next_y_mode = `ERX_MODE_TTL;
         default: next_y_mode = `ERX_MODE_RS422;
      endcase // RULE18
   end

   // htl receivers get single-ended thresholds when selected
   wire [2:0] htl_rx;
   assign htl_rx = {(next_a_mode == `ERX_MODE_DHTL) ||
                       (next_a_mode == `ERX_MODE_SEHTL),
                    (next_b_mode == `ERX_MODE_DHTL) ||
                       (next_b_mode == `ERX_MODE_SEHTL),
                    (next_z_mode == `ERX_MODE_DHTL) ||
                       (next_z_mode == `ERX_MODE_SEHTL)};

   // registered mode outputs
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_mode_o <= `ERX_MODE_DHTL;
         b_mode_o <= `ERX_MODE_DHTL;
         z_mode_o <= `ERX_MODE_DHTL;
         y_mode_o <= `ERX_MODE_RS422;
         aux2_mode_o <= `ERX_MODE_TTL;
         aux3_mode_o <= `ERX_MODE_TTL;
         se_htl_thresh_o <= 3'h0;
         diff_filter_en_o <= 1'b0;
      end else begin
         a_mode_o <= next_a_mode;
         b_mode_o <= next_b_mode;
         z_mode_o <= next_z_mode;
         y_mode_o <= next_y_mode;
         // aux receivers: one select bit each
         aux2_mode_o <= cfg[`ERX_BIT_D2_DI] ? `ERX_MODE_DI :
                                              `ERX_MODE_TTL; // RULE19
         aux3_mode_o <= cfg[`ERX_BIT_D3_DI] ? `ERX_MODE_DI :
                                              `ERX_MODE_TTL; // RULE19
         se_htl_thresh_o <= {3{cfg[`ERX_BIT_HIGH_THRESHOLD_SEL]}} &
                            htl_rx; // RULE6
         diff_filter_en_o <= diff_filter_en;
      end
   end
endmodule // erx_spi_cmd
`default_nettype wire

// >>> hdl/erx_defines.vh
`ifndef ERX_DEFINES_VH
`define ERX_DEFINES_VH

// system clock rate and filter times
`define ERX_SYS_CLK_MHZ 250
`define ERX_LONG_FILTER_US 1000
`define ERX_SHORT_FILTER_US 10
// filter counts at that clock rate, sized to the filter counter
`define ERX_LONG_FILTER_CYC 18'h3D090
`define ERX_SHORT_FILTER_CYC 18'h009C4
`define ERX_FILTER_CNT_W 18

// frame layout, msb first
`define ERX_FRAME_BITS 5'h10
`define ERX_CMD_HI 15
`define ERX_CMD_LO 13
`define ERX_MODE_W 13

// command codes
`define ERX_CMD_CONFIG_WRITE 3'h5
`define ERX_CMD_STATUS_READ 3'h2
`define ERX_CMD_CONFIG_READ 3'h7

// response selected for the next frame
`define ERX_RESP_ZERO 2'h0
`define ERX_RESP_DETAIL 2'h1
`define ERX_RESP_STATUS 2'h2
`define ERX_RESP_CONFIG 2'h3

// mode bit positions inside the 13 mode bits
`define ERX_BIT_HIGH_THRESHOLD_SEL 12
`define ERX_BIT_DIFF_FILTER_EN 11
`define ERX_BIT_A_SINGLE_ENDED_SEL 10
`define ERX_BIT_A_TTL 9
`define ERX_BIT_B_SINGLE_ENDED_SEL 8
`define ERX_BIT_B_TTL 7
`define ERX_BIT_Z_TTL 6
`define ERX_BIT_Z_SINGLE_ENDED_SEL 5
`define ERX_BIT_Z_DI 4
`define ERX_BIT_Y_TTL 3
`define ERX_BIT_Y_SINGLE_ENDED_SEL 2
`define ERX_BIT_D2_DI 1
`define ERX_BIT_D3_DI 0
`define ERX_CFG_RESET 13'h0000

// receiver operating modes
`define ERX_MODE_DHTL 3'h0
`define ERX_MODE_RS422 3'h1
`define ERX_MODE_SEHTL 3'h2
`define ERX_MODE_TTL 3'h3
`define ERX_MODE_DI 3'h4

`endif

// >>> hdl/erx_sync.v
`timescale 1ns/1ps
`default_nettype none
// two flip-flop synchroniser for a bundle of asynchronous levels
module erx_sync #(
   parameter W = 1,
   // reset value, the idle level of each pin
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule // erx_sync
`default_nettype wire

// >>> hdl/erx_fault_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "erx_defines.vh"
// qualifies a fault level: it must stand for a full delay to assert
module erx_fault_filter #(
   parameter [`ERX_FILTER_CNT_W-1:0] LONG_CYC = `ERX_LONG_FILTER_CYC,
   parameter [`ERX_FILTER_CNT_W-1:0] SHORT_CYC = `ERX_SHORT_FILTER_CYC
) (
   input wire clk_sys_i,
   input wire nrst_i,
   input wire raw_i,
   input wire short_i,
   output reg qual_o
);
   reg [`ERX_FILTER_CNT_W-1:0] cnt;
   wire [`ERX_FILTER_CNT_W-1:0] limit;

   assign limit = short_i ? SHORT_CYC : LONG_CYC;

   // count while present, drop at once when the fault goes away
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= {`ERX_FILTER_CNT_W{1'b0}};
         qual_o <= 1'b0;
      end else if (!raw_i) begin
         cnt <= {`ERX_FILTER_CNT_W{1'b0}};
         qual_o <= 1'b0;
      end else if (cnt >= limit - 1'b1) begin
         qual_o <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end
endmodule // erx_fault_filter
`default_nettype wire

// >>> bench/erx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host spi master, mode 0; its clock stands still between frames
module erx_host_model (
   input wire logic clk_sys_i,
   input wire logic sdo_i,
   output var logic cs_n_o,
   output var logic sclk_o,
   output var logic sdi_o
);
   // idle levels before the first frame
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // one frame of n clocks, msb first; rx keeps the last 16 bits seen
   task automatic xfer(input int n, input logic [31:0] tx,
                       output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk_sys_i) cs_n_o <= 1'b0;
      for (int k = n - 1; k >= 0; k--) begin
         repeat (10) @(posedge clk_sys_i);
         sdi_o <= tx[k];
         repeat (10) @(posedge clk_sys_i);
         sclk_o <= 1'b1;
         rx = {rx[14:0], sdo_i};
         repeat (20) @(posedge clk_sys_i);
         sclk_o <= 1'b0;
      end
      repeat (20) @(posedge clk_sys_i);
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o; // released line shows no stale level
      repeat (20) @(posedge clk_sys_i);
   endtask
endmodule // erx_host_model
`default_nettype wire

// >>> bench/erx_spi_cmd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "erx_defines.vh"
// port checks for the command and fault block
module erx_spi_cmd_asserts #(
   parameter [`ERX_FILTER_CNT_W-1:0] LONG_FILTER_CYC = `ERX_LONG_FILTER_CYC
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic chip_select_pin_n_i,
   input wire logic serial_clock_pin_i,
   input wire logic [3:0] diff_fault_i,
   input wire logic [11:0] se_fault_i,
   input wire logic serial_out_pin_o,
   input wire logic shared_interrupt_n_o,
   input wire logic [5:0] fault_o,
   input wire logic [2:0] a_mode_o,
   input wire logic diff_filter_en_o
);
   localparam int SHORT = `ERX_SHORT_FILTER_CYC;
   int se_cnt;
   int d_cnt;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   // how long the aux3 and the a differential faults have stood
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         se_cnt <= 0;
         d_cnt <= 0;
      end else begin
         se_cnt <= (se_fault_i[1:0] != 2'h0) ? se_cnt + 1 : 0;
         d_cnt <= diff_fault_i[3] ? d_cnt + 1 : 0;
      end
   end
   a_irq_on_fault: assert property (
      (fault_o & ~$past(fault_o)) != 6'h00 |-> !shared_interrupt_n_o)
      else $error("fault without interrupt");
   a_irq_release: assert property (
      $rose(shared_interrupt_n_o) |-> chip_select_pin_n_i)
      else $error("interrupt freed mid frame");
   a_se_late: assert property (
      $rose(fault_o[0]) |-> se_cnt >= LONG_FILTER_CYC - 2)
      else $error("se fault too early");
   a_se_timely: assert property (
      se_cnt == LONG_FILTER_CYC + 10 |-> fault_o[0])
      else $error("se fault too late");
   a_diff_fast: assert property (
      $rose(fault_o[5]) && !diff_filter_en_o
      |-> d_cnt >= SHORT - 2 && d_cnt <= SHORT + 10)
      else $error("short diff filter off");
   a_diff_slow: assert property (
      $rose(fault_o[5]) && diff_filter_en_o
      |-> d_cnt >= LONG_FILTER_CYC - 2)
      else $error("long diff filter off");
   a_fault_drop: assert property (
      $fell(diff_fault_i[3]) && se_fault_i[11:10] == 2'h0
      |-> ##[1:5] !fault_o[5])
      else $error("fault output stuck");
   a_sdo_on_fall: assert property (
      serial_clock_pin_i && $past(serial_clock_pin_i, 5)
      |-> $stable(serial_out_pin_o))
      else $error("data out moved in clock high");
   a_cfg_at_end: assert property (
      $changed(a_mode_o) |-> chip_select_pin_n_i)
      else $error("mode changed mid frame");
   // main scenarios reached
   c_irq_set: cover property ($fell(shared_interrupt_n_o));
   c_irq_clr: cover property ($rose(shared_interrupt_n_o));
   c_cfg: cover property ($changed(a_mode_o));
endmodule // erx_spi_cmd_asserts
`default_nettype wire

// >>> bench/encoder_rx_spi_cmd_fault_logic_bench.sv
`timescale 1ns/1ps
`default_nettype none
module encoder_rx_spi_cmd_fault_logic_bench;
   localparam int LONG = 3000;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic chip_select_pin_n_i, serial_clock_pin_i, serial_in_pin_i;
   logic [3:0] diff_fault_i = 4'h0;
   logic [11:0] se_fault_i = 12'h000;
   logic [5:0] rx_level_i = 6'h00;
   logic serial_out_pin_o, shared_interrupt_n_o, diff_filter_en_o;
   logic [5:0] fault_o;
   logic [2:0] a_mode_o, b_mode_o, z_mode_o, y_mode_o;
   logic [2:0] aux2_mode_o, aux3_mode_o, se_htl_thresh_o;
   logic [15:0] rx;
   logic [12:0] m;
   logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
   int errors = 0;
   int samples_checked = 0;
   // system clock
   always #2 clk_sys_i = ~clk_sys_i;
   erx_spi_cmd #(.LONG_FILTER_CYC(LONG)) dut (
      .clk_sys_i, .nrst_i, .chip_select_pin_n_i, .serial_clock_pin_i,
      .serial_in_pin_i, .diff_fault_i, .se_fault_i, .rx_level_i,
      .serial_out_pin_o, .shared_interrupt_n_o, .fault_o, .a_mode_o,
      .b_mode_o, .z_mode_o, .y_mode_o, .aux2_mode_o, .aux3_mode_o,
      .se_htl_thresh_o, .diff_filter_en_o);
   erx_host_model host (
      .clk_sys_i, .sdo_i(serial_out_pin_o), .cs_n_o(chip_select_pin_n_i),
      .sclk_o(serial_clock_pin_i), .sdi_o(serial_in_pin_i));
   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one 16 clock frame and its response word
   task automatic frame(input logic [2:0] c, input logic [12:0] md,
                        input logic [15:0] e);
      host.xfer(16, {16'h0000, c, md}, rx);
      check(rx, e);
   endtask
   // mode outputs against the selection tables
   task automatic check_modes(input logic [12:0] c);
      check(a_mode_o, {1'b0, c[10], c[9]});
      check(b_mode_o, {1'b0, c[8], c[7]});
      check(z_mode_o, c[4] ? 3'h4 : {1'b0, c[5], c[6]});
      check(y_mode_o, c[2] ? (c[3] ? 3'h3 : 3'h4) : 3'h1);
      check(aux2_mode_o, c[1] ? 3'h4 : 3'h3);
      check(aux3_mode_o, c[0] ? 3'h4 : 3'h3);
      check(se_htl_thresh_o, {3{c[12]}} & ~{c[9], c[7], c[6] | c[4]});
      check(diff_filter_en_o, c[11]);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      frame(3'h7, 13'h1FFF, 16'h0000);
      check_modes(13'h0000);
      for (int i = 0; i < 5; i++) begin
         diff_fault_i <= i[0] ? 4'hA : 4'h5;
         se_fault_i <= i[0] ? 12'h5A3 : 12'hA5C;
         m = {i[0], 1'b0, i[1], i[0], i[0], i[1], i[1], i[0], i[2],
              i[1], i[0], i[0], ~i[0]};
         frame(3'h5, m, i == 0 ? 16'h0 : i[0] ? 16'h6AC3 : 16'h953C);
         check_modes(m);
         // one idle cycle so no filter runs on across frames
         diff_fault_i <= 4'h0;
         se_fault_i <= 12'h000;
         @(posedge clk_sys_i);
      end
      diff_fault_i <= 4'h0;
      se_fault_i <= 12'h000;
      frame(3'h7, 13'h1FFF, 16'h0000);
      frame(3'h0, 13'h1FFF, {3'h0, m});
      foreach (codes[k]) begin
         frame(codes[k], 13'h1FFF, 16'h0000);
         check_modes(m);
      end
      host.xfer(15, {17'h0, 15'h7FFF}, rx);
      check(rx, 16'h0000);
      check_modes(m);
      m = 13'h1000;
      host.xfer(20, {12'h0, 4'hF, 3'h5, m}, rx);
      check(rx, 16'h000F);
      check_modes(m);
      rx_level_i <= 6'h2D;
      diff_fault_i <= 4'h8;
      repeat (2400) @(posedge clk_sys_i);
      check(fault_o, 16'h0000);
      repeat (200) @(posedge clk_sys_i);
      check(fault_o, 16'h0020);
      check(shared_interrupt_n_o, 16'h0000);
      frame(3'h2, 13'h0000, 16'h2000);
      check(shared_interrupt_n_o, 16'h0001);
      check(fault_o, 16'h0020);
      fork
         frame(3'h0, 13'h0000, {6'h20, 6'h2D, 4'h0});
         begin
            repeat (100) @(posedge clk_sys_i);
            rx_level_i <= 6'h12;
         end
      join
      diff_fault_i <= 4'h0;
      repeat (10) @(posedge clk_sys_i);
      check(fault_o, 16'h0000);
      se_fault_i <= 12'h001;
      repeat (2900) @(posedge clk_sys_i);
      check(fault_o, 16'h0000);
      repeat (200) @(posedge clk_sys_i);
      check(fault_o, 16'h0001);
      se_fault_i <= 12'h000;
      repeat (10) @(posedge clk_sys_i);
      check(shared_interrupt_n_o, 16'h0000);
      frame(3'h5, 13'h0800, 16'h0000);
      check(shared_interrupt_n_o, 16'h0001);
      diff_fault_i <= 4'h8;
      repeat (2700) @(posedge clk_sys_i);
      check(fault_o, 16'h0000);
      repeat (400) @(posedge clk_sys_i);
      check(fault_o, 16'h0020);
      print_verdict;
   end
   // cut a hung run short
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      print_verdict;
   end
endmodule // encoder_rx_spi_cmd_fault_logic_bench
bind erx_spi_cmd erx_spi_cmd_asserts
   #(.LONG_FILTER_CYC(LONG_FILTER_CYC)) chk (
   .clk_sys_i, .nrst_i, .chip_select_pin_n_i, .serial_clock_pin_i,
   .diff_fault_i, .se_fault_i, .serial_out_pin_o, .shared_interrupt_n_o,
   .fault_o, .a_mode_o, .diff_filter_en_o);
`default_nettype wire
